// File: far_pkg.sv
// shared constants and types of the fault auto restart controller
package far_pkg;
  // clock and time bases
  localparam int CLK_KHZ = 125000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
  localparam int RIDE_MS = 15;
  localparam int RIDE_CYCLES = CLK_KHZ * RIDE_MS;
  localparam int TRIPFREE_S = 60;
  localparam logic [9:0] TRIPFREE_TICKS = 10'(TRIPFREE_S * 1000 / TICK_MS);
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LIMIT = 6'h04;
  localparam logic [5:0] OFS_WAIT = 6'h08;
  localparam logic [5:0] OFS_INHIBIT = 6'h0c;
  localparam logic [5:0] OFS_CURRENT = 6'h10;
  localparam logic [5:0] OFS_PGAIN = 6'h14;
  localparam logic [5:0] OFS_IGAIN = 6'h18;
  localparam logic [5:0] OFS_SEL = 6'h1c;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h24;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
  // reset values and ranges
  localparam logic RST_EN = 1'b0;
  localparam logic [3:0] RST_LIMIT = 4'h0;
  localparam logic [3:0] MAX_LIMIT = 4'ha;
  localparam logic [9:0] RST_WAIT = 10'h00a;
  localparam logic [9:0] RST_INHIBIT = 10'h00a;
  localparam logic [9:0] MAX_TIME = 10'h258;
  localparam logic [7:0] RST_CURRENT = 8'h96;
  localparam logic [7:0] MIN_CURRENT = 8'h50;
  localparam logic [7:0] MAX_CURRENT = 8'hc8;
  localparam logic [13:0] RST_PGAIN = 14'h0064;
  localparam logic [13:0] RST_IGAIN = 14'h00c8;
  localparam logic [13:0] MAX_GAIN = 14'h270f;
  localparam logic [3:0] RST_SEL = 4'h0;
  // interrupt bit positions
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_LOCKOUT = 2;
  localparam int IRQ_UNDERVOLT = 3;
  localparam int IRQ_REFILL = 4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // trip causes
  localparam logic [2:0] CAUSE_OVERCURRENT = 3'h0;
  localparam logic [2:0] CAUSE_OVERLOAD = 3'h1;
  localparam logic [2:0] CAUSE_OTHER = 3'h2;
  localparam logic [2:0] CAUSE_UNDERVOLT = 3'h3;
  localparam logic [2:0] CAUSE_ESTOP = 3'h4;
  localparam logic [2:0] CAUSE_OVERHEAT = 3'h5;
  localparam logic [2:0] CAUSE_HWDIAG = 3'h6;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_TRIP = 5'h02,
    ST_WAIT = 5'h04,
    ST_BLOCK = 5'h08,
    ST_SEARCH = 5'h10
  } far_state_type;
endpackage

// File: far_tick_if.sv
// tick link between the controller and its time base
`timescale 1ns/1ps
`default_nettype none
interface far_tick_if;
  logic tick;
  logic sync_clr;
  modport gen (input sync_clr, output tick);
  modport use_side (output sync_clr, input tick);
endinterface
`default_nettype wire

// File: far_timebase.sv
// 0.1 s tick divider for the restart timers
`timescale 1ns/1ps
`default_nettype none
module far_timebase #(
  parameter int CYCLES = far_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  far_tick_if.gen tb
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } far_tb_type;
  far_tb_type s_r, s_nxt;

  // restart the divider on clear so each phase starts a full period
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (tb.sync_clr) begin
      s_nxt.cnt = 32'h0;
    end else if (s_r.cnt == 32'(CYCLES - 1)) begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tb.tick = s_r.tick;

  tick_spacing_a: assert property (@(posedge clk) disable iff (srst)
    s_r.tick |-> s_r.cnt == 32'h0)
    else $error("tick not aligned to divider wrap");
endmodule // far_timebase
`default_nettype wire

// File: far_restart.sv
// fault trip auto restart controller with axi4-lite registers
// How it works
// - restarts happen only while the restart enable bit is one; the code checks it only at the trip, not while a restart runs.
// - after a trip the block waits the programmed retry time first.
// - each restart takes one from the retry count; at zero none follow.
// - the retry limit takes 0 to 10, default 0.
// - 60 s without a trip after a restart gives back one retry, up to the limit.
// - undervoltage, emergency stop, overheat and diagnosis trips never restart.
// - each restart runs through the speed search with its own settings.
// - the output stays blocked for the inhibit time before the search.
// - the search start current takes 80 to 200 percent, default 150.
// - proportional gain 0 to 9999 default 100, integral 0 to 9999 default 200.
// - the search selection is four independent bits.
// - power loss up to 15 ms rides through; longer gives undervoltage.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module far_restart #(
  parameter int TICK_CYCLES = far_pkg::TICK_CYCLES,
  parameter int RIDE_CYCLES = far_pkg::RIDE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trip_valid,
  input wire logic [2:0] trip_cause,
  input wire logic emergency_stop_input,
  input wire logic power_ok,
  input wire logic fault_reset,
  input wire logic search_done,
  output logic drive_run,
  output logic output_block,
  output logic tripped,
  output logic search_start,
  output logic [7:0] search_current,
  output logic [13:0] search_pgain,
  output logic [13:0] search_igain,
  output logic [3:0] search_select,
  output logic irq
);
  typedef struct packed {
    far_pkg::far_state_type st;
    logic [3:0] count;
    logic [9:0] ticks;
    logic [9:0] good_ticks;
    logic good_run;
    logic [31:0] ride;
    logic start_p;
    logic [2:0] cause;
    logic en;
    logic [3:0] limit;
    logic [9:0] wait_t;
    logic [9:0] inhibit;
    logic [7:0] cur;
    logic [13:0] pg;
    logic [13:0] ig;
    logic [3:0] sel;
    logic [4:0] ist;
    logic [4:0] imask;
    logic aw_h;
    logic [5:0] awaddr;
    logic w_h;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } far_regs_type;

  far_regs_type s_r, s_nxt;
  far_tick_if tb_if ();

  far_timebase #(.CYCLES(TICK_CYCLES)) u_tb (
    .clk(clk),
    .srst(srst),
    .tb(tb_if.gen)
  );

  // merge write strobes into the old value
  function automatic logic [31:0] far_strb(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // clip a setting into its legal range
  function automatic logic [15:0] far_clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // causes that must never lead to a restart
  function automatic logic far_restartable(input logic [2:0] c);
    return !(c == far_pkg::CAUSE_UNDERVOLT || c == far_pkg::CAUSE_ESTOP ||
      c == far_pkg::CAUSE_OVERHEAT || c == far_pkg::CAUSE_HWDIAG);
  endfunction

  logic uv_fire, trip_ev, wr_go, ar_go;
  logic [2:0] cause_now;
  logic [4:0] ist_set, ist_clr;
  logic [31:0] wr_old, wr_val;

  // trip sources: a long power loss and the stop input outrank the stage
  always_comb begin
    uv_fire = !power_ok && s_r.ride == 32'(RIDE_CYCLES - 1);
    trip_ev = trip_valid || emergency_stop_input || uv_fire;
    if (uv_fire) begin
      cause_now = far_pkg::CAUSE_UNDERVOLT;
    end else if (emergency_stop_input) begin
      cause_now = far_pkg::CAUSE_ESTOP;
    end else begin
      cause_now = trip_cause;
    end
    wr_go = s_r.aw_h && s_r.w_h && !s_r.bvalid;
    ar_go = s_axi_arvalid && !s_r.rvalid;
  end

  // old value of the addressed register, for strobe merging
  always_comb begin
    case (s_r.awaddr)
      far_pkg::OFS_CTRL: wr_old = {31'h0, s_r.en};
      far_pkg::OFS_LIMIT: wr_old = {28'h0, s_r.limit};
      far_pkg::OFS_WAIT: wr_old = {22'h0, s_r.wait_t};
      far_pkg::OFS_INHIBIT: wr_old = {22'h0, s_r.inhibit};
      far_pkg::OFS_CURRENT: wr_old = {24'h0, s_r.cur};
      far_pkg::OFS_PGAIN: wr_old = {18'h0, s_r.pg};
      far_pkg::OFS_IGAIN: wr_old = {18'h0, s_r.ig};
      far_pkg::OFS_SEL: wr_old = {28'h0, s_r.sel};
      far_pkg::OFS_IRQ_MASK: wr_old = {27'h0, s_r.imask};
      default: wr_old = 32'h0;
    endcase
    wr_val = far_strb(wr_old, s_r.wdata, s_r.wstrb);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.start_p = 1'b0;
    ist_set = 5'h0;
    ist_clr = 5'h0;
    // power-loss ride-through counter, saturating at the trip point
    if (power_ok) begin
      s_nxt.ride = 32'h0;
    end else if (!uv_fire) begin
      s_nxt.ride = s_r.ride + 32'h1;
    end
    if (uv_fire) begin
      ist_set[far_pkg::IRQ_UNDERVOLT] = 1'b1;
    end

    // restart sequencer
    if (trip_ev && s_r.st != far_pkg::ST_TRIP) begin
      ist_set[far_pkg::IRQ_TRIP] = 1'b1;
      s_nxt.cause = cause_now;
      s_nxt.ticks = 10'h0;
      s_nxt.good_run = 1'b0;
      if (s_r.en && far_restartable(cause_now) &&
          s_r.count != 4'h0) begin
        s_nxt.st = far_pkg::ST_WAIT;
      end else begin
        s_nxt.st = far_pkg::ST_TRIP;
        ist_set[far_pkg::IRQ_LOCKOUT] = 1'b1;
      end
    end else begin
      case (s_r.st)
        far_pkg::ST_TRIP: begin
          // only an outside fault reset leaves the tripped state
          if (fault_reset) begin
            s_nxt.st = far_pkg::ST_RUN;
            s_nxt.count = s_r.limit;
          end
        end
        far_pkg::ST_WAIT: begin
          if (s_r.ticks >= s_r.wait_t) begin
            s_nxt.st = far_pkg::ST_BLOCK;
            s_nxt.ticks = 10'h0;
            s_nxt.count = s_r.count - 4'h1;
            ist_set[far_pkg::IRQ_RESTART] = 1'b1;
          end else if (tb_if.tick) begin
            s_nxt.ticks = s_r.ticks + 10'h1;
          end
        end
        far_pkg::ST_BLOCK: begin
          if (s_r.ticks >= s_r.inhibit) begin
            s_nxt.st = far_pkg::ST_SEARCH;
            s_nxt.start_p = 1'b1;
          end else if (tb_if.tick) begin
            s_nxt.ticks = s_r.ticks + 10'h1;
          end
        end
        far_pkg::ST_SEARCH: begin
          if (search_done) begin
            s_nxt.st = far_pkg::ST_RUN;
            s_nxt.good_run = 1'b1;
            s_nxt.good_ticks = 10'h0;
          end
        end
        far_pkg::ST_RUN: begin
          // trip-free interval gives back retries one at a time
          if (s_r.good_run && tb_if.tick) begin
            if (s_r.good_ticks + 10'h1 >= far_pkg::TRIPFREE_TICKS) begin
              s_nxt.good_ticks = 10'h0;
              if (s_r.count < s_r.limit) begin
                s_nxt.count = s_r.count + 4'h1;
                ist_set[far_pkg::IRQ_REFILL] = 1'b1;
              end
              s_nxt.good_run = (s_r.count + 4'h1) < s_r.limit;
            end else begin
              s_nxt.good_ticks = s_r.good_ticks + 10'h1;
            end
          end
        end
        default: s_nxt.st = far_pkg::ST_TRIP;
      endcase
    end

    // axi write channel: address and data taken in either order
    if (s_axi_awvalid && !s_r.aw_h && !s_r.bvalid) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.awaddr = {s_axi_awaddr[5:2], 2'h0};
    end
    if (s_axi_wvalid && !s_r.w_h && !s_r.bvalid) begin
      s_nxt.w_h = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = far_pkg::RESP_OKAY;
      // out-of-range settings are clipped, not refused
      case (s_r.awaddr)
        far_pkg::OFS_CTRL: s_nxt.en = wr_val[0];
        far_pkg::OFS_LIMIT: begin
          s_nxt.limit = 4'(far_clamp({12'h0, wr_val[3:0]}, 16'h0,
            {12'h0, far_pkg::MAX_LIMIT}));
          // clip against the count as it ends this cycle, so a fault
          // reset or refill landing in the same cycle cannot overshoot
          if (s_nxt.count > s_nxt.limit) begin
            s_nxt.count = s_nxt.limit;
          end
        end
        far_pkg::OFS_WAIT: s_nxt.wait_t = 10'(far_clamp(wr_val[15:0], 16'h0,
          {6'h0, far_pkg::MAX_TIME}));
        far_pkg::OFS_INHIBIT: s_nxt.inhibit = 10'(far_clamp(wr_val[15:0],
          16'h0, {6'h0, far_pkg::MAX_TIME}));
        far_pkg::OFS_CURRENT: s_nxt.cur = 8'(far_clamp(wr_val[15:0],
          {8'h0, far_pkg::MIN_CURRENT}, {8'h0, far_pkg::MAX_CURRENT}));
        far_pkg::OFS_PGAIN: s_nxt.pg = 14'(far_clamp(wr_val[15:0], 16'h0,
          {2'h0, far_pkg::MAX_GAIN}));
        far_pkg::OFS_IGAIN: s_nxt.ig = 14'(far_clamp(wr_val[15:0], 16'h0,
          {2'h0, far_pkg::MAX_GAIN}));
        far_pkg::OFS_SEL: s_nxt.sel = wr_val[3:0];
        far_pkg::OFS_STATUS: ;
        far_pkg::OFS_IRQ_STAT: ist_clr = s_r.wdata[4:0] & {5{s_r.wstrb[0]}};
        far_pkg::OFS_IRQ_MASK: s_nxt.imask = wr_val[4:0];
        default: s_nxt.bresp = far_pkg::RESP_SLVERR;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    s_nxt.ist = (s_r.ist & ~ist_clr) | ist_set;

    // axi read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = far_pkg::RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'h0})
        far_pkg::OFS_CTRL: s_nxt.rdata = {31'h0, s_r.en};
        far_pkg::OFS_LIMIT: s_nxt.rdata = {28'h0, s_r.limit};
        far_pkg::OFS_WAIT: s_nxt.rdata = {22'h0, s_r.wait_t};
        far_pkg::OFS_INHIBIT: s_nxt.rdata = {22'h0, s_r.inhibit};
        far_pkg::OFS_CURRENT: s_nxt.rdata = {24'h0, s_r.cur};
        far_pkg::OFS_PGAIN: s_nxt.rdata = {18'h0, s_r.pg};
        far_pkg::OFS_IGAIN: s_nxt.rdata = {18'h0, s_r.ig};
        far_pkg::OFS_SEL: s_nxt.rdata = {28'h0, s_r.sel};
        far_pkg::OFS_STATUS: s_nxt.rdata = {19'h0, s_r.st, 1'b0, s_r.cause,
          s_r.count};
        far_pkg::OFS_IRQ_STAT: s_nxt.rdata = {27'h0, s_r.ist};
        far_pkg::OFS_IRQ_MASK: s_nxt.rdata = {27'h0, s_r.imask};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = far_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // state register; retry budget starts at the default limit of zero
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= far_pkg::ST_RUN;
      s_r.en <= far_pkg::RST_EN;
      s_r.limit <= far_pkg::RST_LIMIT;
      s_r.count <= far_pkg::RST_LIMIT;
      s_r.wait_t <= far_pkg::RST_WAIT;
      s_r.inhibit <= far_pkg::RST_INHIBIT;
      s_r.cur <= far_pkg::RST_CURRENT;
      s_r.pg <= far_pkg::RST_PGAIN;
      s_r.ig <= far_pkg::RST_IGAIN;
      s_r.sel <= far_pkg::RST_SEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // divider restarts on every state change so timing begins on entry
  assign tb_if.sync_clr = s_nxt.st != s_r.st;

  // outputs
  assign s_axi_awready = !s_r.aw_h && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_h && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign drive_run = s_r.st == far_pkg::ST_RUN ||
    s_r.st == far_pkg::ST_SEARCH;
  assign output_block = !drive_run;
  assign tripped = s_r.st == far_pkg::ST_TRIP;
  assign search_start = s_r.start_p;
  assign search_current = s_r.cur;
  assign search_pgain = s_r.pg;
  assign search_igain = s_r.ig;
  assign search_select = s_r.sel;
  assign irq = |(s_r.ist & s_r.imask);

  // checks
  no_enable_a: assert property (@(posedge clk) disable iff (srst)
    trip_ev && !s_r.en && !tripped |=> tripped)
    else $error("restart without enable");
  wait_hold_a: assert property (@(posedge clk) disable iff (srst)
    s_r.st == far_pkg::ST_WAIT && !trip_ev && s_r.ticks < s_r.wait_t
    |=> s_r.st == far_pkg::ST_WAIT)
    else $error("wait left early");
  count_dec_a: assert property (@(posedge clk) disable iff (srst)
    s_r.st == far_pkg::ST_WAIT ##1 s_r.st == far_pkg::ST_BLOCK
    |-> s_r.count == $past(s_r.count) - 4'h1)
    else $error("retry count not decremented");
  limit_range_a: assert property (@(posedge clk) disable iff (srst)
    s_r.limit <= far_pkg::MAX_LIMIT && s_r.count <= s_r.limit)
    else $error("retry count out of range");
  excluded_cause_a: assert property (@(posedge clk) disable iff (srst)
    trip_ev && !tripped && !far_restartable(cause_now) |=> tripped)
    else $error("excluded trip restarted");
  search_kick_a: assert property (@(posedge clk) disable iff (srst)
    $rose(s_r.st == far_pkg::ST_SEARCH) |-> search_start
    ##1 !search_start)
    else $error("search start not a single pulse");
  block_out_a: assert property (@(posedge clk) disable iff (srst)
    s_r.st == far_pkg::ST_BLOCK |-> output_block && !drive_run)
    else $error("output not blocked");
  setting_range_a: assert property (@(posedge clk) disable iff (srst)
    s_r.cur >= far_pkg::MIN_CURRENT && s_r.cur <= far_pkg::MAX_CURRENT &&
    s_r.pg <= far_pkg::MAX_GAIN && s_r.ig <= far_pkg::MAX_GAIN)
    else $error("search setting out of range");
  ride_through_a: assert property (@(posedge clk) disable iff (srst)
    uv_fire |-> $past(!power_ok) && s_r.ride == 32'(RIDE_CYCLES - 1))
    else $error("undervoltage before ride-through time");
  lockout_a: assert property (@(posedge clk) disable iff (srst)
    tripped && !fault_reset |=> tripped)
    else $error("tripped state left without fault reset");
  tick_step_a: assert property (@(posedge clk) disable iff (srst)
    s_r.st == far_pkg::ST_WAIT && !tb_if.tick && !trip_ev &&
    s_r.ticks < s_r.wait_t |=> $stable(s_r.ticks))
    else $error("wait counter moved without a tick");
  restart_seen_c: cover property (@(posedge clk) disable iff (srst)
    s_r.st == far_pkg::ST_SEARCH ##1 s_r.st == far_pkg::ST_RUN);
  lockout_seen_c: cover property (@(posedge clk) disable iff (srst)
    $rose(tripped) && s_r.count == 4'h0);
  refill_seen_c: cover property (@(posedge clk) disable iff (srst)
    ist_set[far_pkg::IRQ_REFILL]);
endmodule // far_restart
`default_nettype wire

// File: far_stage_model.sv
// power stage partner: reports trips and catches the spinning motor
`timescale 1ns/1ps
`default_nettype none
module far_stage_model #(
  parameter int SEARCH_CYCLES = 5
) (
  input wire logic clk,
  input wire logic search_start,
  input wire logic fault_req,
  input wire logic [2:0] fault_code,
  output var logic trip_valid = 1'b0,
  output var logic [2:0] trip_cause = 3'h0,
  output var logic search_done = 1'b0
);
  int cnt_r = 0;
  // fault report one cycle after the bench asks for it
  always @(posedge clk) begin
    trip_valid <= fault_req;
    trip_cause <= fault_code;
  end
  // catching a free-running load takes time; done is one pulse
  always @(posedge clk) begin
    search_done <= (cnt_r == 1);
    if (search_start)
      cnt_r <= SEARCH_CYCLES;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end
endmodule // far_stage_model
`default_nettype wire

// File: far_restart_tb_top.sv
// self-checking bench of the fault auto restart controller
`timescale 1ns/1ps
`default_nettype none
module far_restart_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, search_select;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic emergency_stop_input = 1'b0, power_ok = 1'b1, fault_reset = 1'b0;
  logic fault_req = 1'b0;
  logic [2:0] fault_code = 3'h0, trip_cause;
  logic trip_valid, search_done, drive_run, output_block, tripped;
  logic search_start, irq;
  logic [7:0] search_current;
  logic [13:0] search_pgain, search_igain;
  int err_count = 0;
  int compares = 0;

  always #4 clk = ~clk;

  // short tick and ride-through so the run stays brief
  far_restart #(.TICK_CYCLES(10), .RIDE_CYCLES(20)) far_restart_i (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trip_valid, .trip_cause,
    .emergency_stop_input, .power_ok, .fault_reset, .search_done,
    .drive_run, .output_block, .tripped, .search_start, .search_current,
    .search_pgain, .search_igain, .search_select, .irq);

  far_stage_model far_stage_model_i (
    .clk, .search_start, .fault_req, .fault_code, .trip_valid,
    .trip_cause, .search_done);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one axi write; aw and w offered together, released as taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
      output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge so a following call never re-raises bready at once
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d,
      output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
  endtask

  // remaining retries sit in the low status nibble
  task automatic left(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(far_pkg::OFS_STATUS, d, r);
    check(32'(d[3:0]), exp);
  endtask

  task automatic trip(input logic [2:0] c);
    fault_req <= 1'b1;
    fault_code <= c;
    @(posedge clk);
    fault_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic frst();
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // bounded wait for the search launch, then let the motor catch
  task automatic catch(output int n);
    n = 0;
    while (search_start !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // whole run needs about 6.5k cycles; this allows over fifteen times that
  initial begin
    #800000;
    err_count++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // defaults and clamping of the settings
    rchk(far_pkg::OFS_CTRL, 32'h0);
    rchk(far_pkg::OFS_LIMIT, 32'h0);
    rchk(far_pkg::OFS_WAIT, 32'h00a);
    rchk(far_pkg::OFS_INHIBIT, 32'h00a);
    rchk(far_pkg::OFS_CURRENT, 32'h96);
    rchk(far_pkg::OFS_PGAIN, 32'h64);
    rchk(far_pkg::OFS_IGAIN, 32'hc8);
    rchk(far_pkg::OFS_SEL, 32'h0);
    wr(far_pkg::OFS_LIMIT, 32'hf, r);
    rchk(far_pkg::OFS_LIMIT, 32'ha);
    wr(far_pkg::OFS_CURRENT, 32'h14, r);
    check(32'(search_current), 32'h50);
    wr(far_pkg::OFS_IGAIN, 32'hffff, r);
    check(32'(search_igain), 32'h270f);
    wr(far_pkg::OFS_PGAIN, 32'h2710, r);
    check(32'(search_pgain), 32'h270f);
    wr(far_pkg::OFS_SEL, 32'hf, r);
    check(32'(search_select), 32'hf);
    wr(far_pkg::OFS_INHIBIT, 32'h3e8, r);
    rchk(far_pkg::OFS_INHIBIT, 32'h258);
    wr(6'h30, 32'h1, r);
    check(32'(r), 32'(far_pkg::RESP_SLVERR));
    rd(6'h30, d, r);
    check(32'(r), 32'(far_pkg::RESP_SLVERR));
    wr(far_pkg::OFS_WAIT, 32'h1, r);
    wr(far_pkg::OFS_INHIBIT, 32'h1, r);
    // restart disabled: a trip stays tripped; interrupt raised, cleared
    wr(far_pkg::OFS_IRQ_MASK, 32'h1, r);
    trip(far_pkg::CAUSE_OVERCURRENT);
    check(32'(tripped), 32'h1);
    check(32'(irq), 32'h1);
    wr(far_pkg::OFS_IRQ_STAT, 32'h1f, r);
    check(32'(irq), 32'h0);
    // two retries allowed
    wr(far_pkg::OFS_CTRL, 32'h1, r);
    wr(far_pkg::OFS_LIMIT, 32'h2, r);
    frst();
    left(32'h2);
    trip(far_pkg::CAUSE_OVERLOAD);
    check(32'({output_block, tripped}), 32'h2);
    catch(n);
    check(32'(n + 4 >= 20 && n + 4 <= 30), 32'h1);
    check(32'(drive_run), 32'h1);
    // drive_run is also high while searching: the state must be run
    rd(far_pkg::OFS_STATUS, d, r);
    check(32'(d[12:8]), 32'(far_pkg::ST_RUN));
    left(32'h1);
    // one retry comes back only after 600 trip-free ticks
    repeat (5900) @(posedge clk);
    left(32'h1);
    repeat (150) @(posedge clk);
    left(32'h2);
    trip(far_pkg::CAUSE_OTHER);
    catch(n);
    trip(far_pkg::CAUSE_OTHER);
    catch(n);
    left(32'h0);
    trip(far_pkg::CAUSE_OVERCURRENT);
    repeat (40) @(posedge clk);
    check(32'(tripped), 32'h1);
    // excluded causes never restart, even with retries left
    for (int i = 3; i <= 6; i++) begin
      frst();
      if (i == 4) begin
        emergency_stop_input <= 1'b1;
        @(posedge clk);
        emergency_stop_input <= 1'b0;
        repeat (3) @(posedge clk);
      end else begin
        trip(3'(i));
      end
      repeat (30) @(posedge clk);
      check(32'(tripped), 32'h1);
    end
    // short power loss rides through, a long one trips
    frst();
    power_ok <= 1'b0;
    repeat (15) @(posedge clk);
    power_ok <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(tripped), 32'h0);
    power_ok <= 1'b0;
    repeat (25) @(posedge clk);
    power_ok <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(tripped), 32'h1);
    stop_test();
  end
endmodule // far_restart_tb_top
`default_nettype wire
